// ### shared/fpm_regs.svh
// timing constants, key indices and limits for the front panel mode controller
`ifndef FPM_REGS_SVH
`define FPM_REGS_SVH

// clock rate and the time base the panel timers count in
`define FPM_CLK_MHZ 250
`define FPM_TICK_US 1000

// times in milliseconds, as the panel behaviour is specified
`define FPM_SHOW_MS 1000
`define FPM_IDLE_MS 20000
`define FPM_HOLD_MS 2000
`define FPM_DEBOUNCE_MS 10

// key positions on the key_pin bus
`define FPM_NKEYS 5
`define FPM_K_MODE 0
`define FPM_K_SHIFT 1
`define FPM_K_UP 2
`define FPM_K_DOWN 3
`define FPM_K_SET 4

// selection ranges
`define FPM_MON_LAST 5'h1A
`define FPM_GRP_LAST 3'h4
`define FPM_CODE_LAST 7'h4F
`define FPM_DIGIT_LAST 3'h4
`define FPM_VAL_W 16

`endif

// ### shared/fpm_pkg.sv
// types shared by the front panel mode controller and its surroundings
package fpm_pkg;

  // panel modes, gray coded along boot, monitor, parameter, edit, save path
  typedef enum logic [2:0] {
    ST_BOOT  = 3'h0,
    ST_MON   = 3'h1,
    ST_PAR   = 3'h3,
    ST_EDIT  = 3'h2,
    ST_WAIT  = 3'h6,
    ST_STAT  = 3'h7,
    ST_ALARM = 3'h5
  } fpm_state_type;

  // answer of the parameter store to a save attempt
  typedef enum logic [2:0] {
    WS_SAVED    = 3'h0,
    WS_READONLY = 3'h1,
    WS_LOCKED   = 3'h2,
    WS_RANGE    = 3'h3,
    WS_SERVO_ON = 3'h4,
    WS_REPOWER  = 3'h5
  } fpm_status_type;

  // everything the display driver needs to render the panel
  typedef struct packed {
    fpm_state_type mode;
    logic show_id;
    logic [4:0] mon_sel;
    logic hex;
    logic [2:0] group;
    logic [6:0] code;
    logic signed [15:0] value;
    logic [2:0] digit;
    fpm_status_type status;
  } fpm_disp_type;

endpackage

// ### rtl/fpm_panel.sv
// front panel keypad and display mode controller
`timescale 1ns/1ps
`include "fpm_regs.svh"

// Behaviour
// - at power-up show monitor identifier one second, then enter monitor mode
// - mode key cycles parameter, monitor, alarm modes
// - alarm mode skipped in the cycle when no alarm is present
// - a new alarm forces alarm mode from any mode
// - alarm present and 20 s without keys returns to alarm mode
// - monitor up/down step monitor variable, identifier shown one second
// - monitor set toggles decimal and hexadecimal display
// - parameter shift steps the group code
// - parameter up/down step the parameter number in the group
// - parameter set enters editing showing the current value
// - editing up/down change value, mode abandons to parameter mode
// - editing shift moves the blinking digit one place left
// - editing set commits the value
// - after a good save show saved code, then back to parameter mode
// - after save attempt show the store status code for one second
// - shift held two seconds inverts sign if result stays in range
module fpm_panel #(
  parameter int unsigned TICK_CYCLES = `FPM_TICK_US * `FPM_CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // operator keys, raw pins, high while pressed
  input wire logic [`FPM_NKEYS-1:0] key_pin,
  // drive alarm source
  input wire logic alarm_new,
  input wire logic alarm_active,
  // parameter store
  input wire logic signed [`FPM_VAL_W-1:0] par_value,
  input wire logic signed [`FPM_VAL_W-1:0] par_min,
  input wire logic signed [`FPM_VAL_W-1:0] par_max,
  input wire logic wr_done,
  input wire fpm_pkg::fpm_status_type wr_status,
  output logic wr_req,
  output logic signed [`FPM_VAL_W-1:0] wr_value,
  // display
  output fpm_pkg::fpm_disp_type disp
);

  // ==========================================================
  // millisecond tick
  logic [31:0] tick_cnt_r;
  logic tick;

  assign tick = (tick_cnt_r == TICK_CYCLES - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // ==========================================================
  // key synchronisers and debouncers
  logic [`FPM_NKEYS-1:0] key_s1_r;
  logic [`FPM_NKEYS-1:0] key_s2_r;
  logic [`FPM_NKEYS-1:0] key_level;
  logic [`FPM_NKEYS-1:0] press;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      key_s1_r <= '0;
      key_s2_r <= '0;
    end else begin
      key_s1_r <= key_pin;
      key_s2_r <= key_s1_r;
    end
  end

  // a key must hold a new level for the whole debounce time to count
  for (genvar k = 0; k < `FPM_NKEYS; k++) begin : g_key
    logic [4:0] deb_r;
    logic stable_r;
    logic press_r;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        deb_r <= 5'h0;
        stable_r <= 1'b0;
        press_r <= 1'b0;
      end else begin
        press_r <= 1'b0;
        if (key_s2_r[k] == stable_r) begin
          deb_r <= 5'h0;
        end else if (tick) begin
          if (deb_r == 5'(`FPM_DEBOUNCE_MS - 1)) begin
            deb_r <= 5'h0;
            stable_r <= key_s2_r[k];
            press_r <= key_s2_r[k];
          end else begin
            deb_r <= deb_r + 5'h1;
          end
        end
      end
    end
    assign key_level[k] = stable_r;
    assign press[k] = press_r;
  end

  logic any_press;
  logic p_mode;
  logic p_shift;
  logic p_up;
  logic p_down;
  logic p_set;

  assign any_press = |press;
  assign p_mode = press[`FPM_K_MODE];
  assign p_shift = press[`FPM_K_SHIFT];
  assign p_up = press[`FPM_K_UP];
  assign p_down = press[`FPM_K_DOWN];
  assign p_set = press[`FPM_K_SET];

  // ==========================================================
  // inactivity timer: fires once when alarm stands and keys are idle
  logic [14:0] idle_ms_r;
  logic idle_fire;

  assign idle_fire = tick && alarm_active &&
                     idle_ms_r == 15'(`FPM_IDLE_MS - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_ms_r <= 15'h0;
    end else if (any_press) begin
      idle_ms_r <= 15'h0;
    end else if (tick && idle_ms_r != 15'(`FPM_IDLE_MS)) begin
      idle_ms_r <= idle_ms_r + 15'h1;
    end
  end

  // ==========================================================
  // shift hold timer for sign inversion, fires once per hold
  logic [11:0] hold_ms_r;
  logic hold_fire;

  assign hold_fire = tick && hold_ms_r == 12'(`FPM_HOLD_MS - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_ms_r <= 12'h0;
    end else if (!key_level[`FPM_K_SHIFT]) begin
      hold_ms_r <= 12'h0;
    end else if (tick && hold_ms_r != 12'(`FPM_HOLD_MS)) begin
      hold_ms_r <= hold_ms_r + 12'h1;
    end
  end

  // ==========================================================
  // edit arithmetic
  function automatic logic signed [16:0] pow10(input logic [2:0] d);
    case (d)
      3'h0: pow10 = 17'sh00001;
      3'h1: pow10 = 17'sh0000A;
      3'h2: pow10 = 17'sh00064;
      3'h3: pow10 = 17'sh003E8;
      default: pow10 = 17'sh02710;
    endcase
  endfunction

  // clamp keeps the edited value inside the store's legal range
  function automatic logic signed [15:0] clamp(
    input logic signed [16:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    if (v < 17'(lo)) begin
      clamp = lo;
    end else if (v > 17'(hi)) begin
      clamp = hi;
    end else begin
      clamp = v[15:0];
    end
  endfunction

  // ==========================================================
  // panel state machine
  fpm_pkg::fpm_state_type state_r;
  logic [10:0] show_ms_r;
  logic show_id_r;
  logic [4:0] mon_sel_r;
  logic hex_r;
  logic [2:0] group_r;
  logic [6:0] code_r;
  logic signed [15:0] edit_r;
  logic [2:0] digit_r;
  fpm_pkg::fpm_status_type status_r;
  logic signed [16:0] edit_neg;
  logic show_done;

  assign edit_neg = -17'(edit_r);
  assign show_done = tick && show_ms_r == 11'h1;

  // one-second display timer for boot, monitor identifier and status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      show_ms_r <= 11'(`FPM_SHOW_MS);
    end else if ((state_r == fpm_pkg::ST_MON && (p_up || p_down)) ||
                 (state_r == fpm_pkg::ST_WAIT && wr_done)) begin
      show_ms_r <= 11'(`FPM_SHOW_MS);
    end else if (tick && show_ms_r != 11'h0) begin
      show_ms_r <= show_ms_r - 11'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= fpm_pkg::ST_BOOT;
      show_id_r <= 1'b1;
    end else if (alarm_new || idle_fire) begin
      state_r <= fpm_pkg::ST_ALARM;
      show_id_r <= 1'b0;
    end else begin
      if (show_done) begin
        show_id_r <= 1'b0;
      end
      case (state_r)
        fpm_pkg::ST_BOOT: begin
          if (show_done) begin
            state_r <= fpm_pkg::ST_MON;
          end
        end
        fpm_pkg::ST_MON: begin
          if (p_mode) begin
            state_r <= alarm_active ? fpm_pkg::ST_ALARM
                                    : fpm_pkg::ST_PAR;
            show_id_r <= 1'b0;
          end else if (p_up || p_down) begin
            show_id_r <= 1'b1;
          end
        end
        fpm_pkg::ST_ALARM: begin
          if (p_mode) begin
            state_r <= fpm_pkg::ST_PAR;
          end
        end
        fpm_pkg::ST_PAR: begin
          if (p_mode) begin
            state_r <= fpm_pkg::ST_MON;
          end else if (p_set) begin
            state_r <= fpm_pkg::ST_EDIT;
          end
        end
        fpm_pkg::ST_EDIT: begin
          if (p_mode) begin
            state_r <= fpm_pkg::ST_PAR;
          end else if (p_set) begin
            state_r <= fpm_pkg::ST_WAIT;
          end
        end
        fpm_pkg::ST_WAIT: begin
          if (wr_done) begin
            state_r <= fpm_pkg::ST_STAT;
          end
        end
        fpm_pkg::ST_STAT: begin
          // a refused save returns to editing so the value can be fixed
          if (show_done) begin
            state_r <= (status_r == fpm_pkg::WS_SAVED ||
                        status_r == fpm_pkg::WS_REPOWER)
                       ? fpm_pkg::ST_PAR : fpm_pkg::ST_EDIT;
          end
        end
        default: state_r <= fpm_pkg::ST_BOOT;
      endcase
    end
  end

  // monitor selection and number format
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mon_sel_r <= 5'h0;
      hex_r <= 1'b0;
    end else if (state_r == fpm_pkg::ST_MON) begin
      if (p_up) begin
        mon_sel_r <= (mon_sel_r == `FPM_MON_LAST) ? 5'h0
                                                  : mon_sel_r + 5'h1;
      end else if (p_down) begin
        mon_sel_r <= (mon_sel_r == 5'h0) ? `FPM_MON_LAST
                                         : mon_sel_r - 5'h1;
      end else if (p_set) begin
        hex_r <= ~hex_r;
      end
    end
  end

  // parameter group and number selection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      group_r <= 3'h0;
      code_r <= 7'h0;
    end else if (state_r == fpm_pkg::ST_PAR) begin
      if (p_shift) begin
        group_r <= (group_r == `FPM_GRP_LAST) ? 3'h0 : group_r + 3'h1;
        code_r <= 7'h0;
      end else if (p_up) begin
        code_r <= (code_r == `FPM_CODE_LAST) ? 7'h0 : code_r + 7'h1;
      end else if (p_down) begin
        code_r <= (code_r == 7'h0) ? `FPM_CODE_LAST : code_r - 7'h1;
      end
    end
  end

  // edited value and blinking digit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edit_r <= 16'sh0000;
      digit_r <= 3'h0;
    end else if (state_r == fpm_pkg::ST_PAR && p_set) begin
      edit_r <= par_value;
      digit_r <= 3'h0;
    end else if (state_r == fpm_pkg::ST_EDIT) begin
      if (p_up) begin
        edit_r <= clamp(17'(edit_r) + pow10(digit_r), par_min, par_max);
      end else if (p_down) begin
        edit_r <= clamp(17'(edit_r) - pow10(digit_r), par_min, par_max);
      end else if (p_shift) begin
        digit_r <= (digit_r == `FPM_DIGIT_LAST) ? 3'h0
                                                : digit_r + 3'h1;
      end else if (hold_fire && edit_neg >= 17'(par_min) &&
                   edit_neg <= 17'(par_max)) begin
        edit_r <= edit_neg[15:0];
      end
    end
  end

  // save request toward the store and its answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_req <= 1'b0;
      wr_value <= 16'sh0000;
      status_r <= fpm_pkg::WS_SAVED;
    end else begin
      wr_req <= state_r == fpm_pkg::ST_EDIT && p_set && !p_mode &&
                !alarm_new && !idle_fire;
      if (state_r == fpm_pkg::ST_EDIT && p_set) begin
        wr_value <= edit_r;
      end
      if (state_r == fpm_pkg::ST_WAIT && wr_done) begin
        status_r <= wr_status;
      end
    end
  end

  // ==========================================================
  // display bundle, all fields straight from registers
  assign disp.mode = state_r;
  assign disp.show_id = show_id_r;
  assign disp.mon_sel = mon_sel_r;
  assign disp.hex = hex_r;
  assign disp.group = group_r;
  assign disp.code = code_r;
  assign disp.value = edit_r;
  assign disp.digit = digit_r;
  assign disp.status = status_r;

endmodule // fpm_panel

// ### sim/fpm_panel_chk.sv
// assertion checker for the front panel mode controller
`timescale 1ns/1ps
module fpm_panel_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // keys, alarm source and store answer
  input wire logic [4:0] key_pin,
  input wire logic alarm_new,
  input wire logic alarm_active,
  input wire logic signed [15:0] par_value,
  input wire logic signed [15:0] par_min,
  input wire logic signed [15:0] par_max,
  input wire logic wr_done,
  input wire fpm_pkg::fpm_status_type wr_status,
  // outputs under watch
  input wire logic wr_req,
  input wire logic signed [15:0] wr_value,
  input wire fpm_pkg::fpm_disp_type disp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================
  // sequences
  sequence s_enter_edit;
    disp.mode == fpm_pkg::ST_PAR ##1 disp.mode == fpm_pkg::ST_EDIT;
  endsequence
  sequence s_saved_exit;
    disp.mode == fpm_pkg::ST_STAT && disp.status == fpm_pkg::WS_SAVED
      ##1 disp.mode != fpm_pkg::ST_STAT;
  endsequence
  // ==========================
  // properties
  boot_exit_a: assert property (disp.mode == fpm_pkg::ST_BOOT |=>
    disp.mode inside {fpm_pkg::ST_BOOT, fpm_pkg::ST_MON, fpm_pkg::ST_ALARM})
    else $error("boot left for a wrong mode");
  alarm_force_a: assert property (alarm_new |=>
    disp.mode == fpm_pkg::ST_ALARM) else $error("new alarm not shown");
  save_pulse_a: assert property (wr_req |->
    $past(disp.mode) == fpm_pkg::ST_EDIT && disp.mode == fpm_pkg::ST_WAIT
    ##1 !wr_req) else $error("save request malformed");
  store_ans_a: assert property (
    disp.mode == fpm_pkg::ST_WAIT && wr_done && !alarm_new |=>
    disp.mode == fpm_pkg::ST_STAT && disp.status == $past(wr_status))
    else $error("store answer not shown");
  saved_back_a: assert property (s_saved_exit |->
    disp.mode inside {fpm_pkg::ST_PAR, fpm_pkg::ST_ALARM})
    else $error("saved code not followed by parameter mode");
  edit_load_a: assert property (s_enter_edit |->
    disp.value == $past(par_value) && disp.digit == 3'h0)
    else $error("edit entry value wrong");
  edit_range_a: assert property (disp.mode == fpm_pkg::ST_EDIT |->
    disp.value >= par_min && disp.value <= par_max)
    else $error("edit value out of range");
  sel_range_a: assert property (disp.mon_sel <= 5'h1A &&
    disp.group <= 3'h4 && disp.code <= 7'h4F && disp.digit <= 3'h4)
    else $error("selection out of range");
endmodule // fpm_panel_chk

bind fpm_panel fpm_panel_chk fpm_panel_chk_i (.core_clk, .rst, .key_pin,
  .alarm_new, .alarm_active, .par_value, .par_min, .par_max, .wr_done,
  .wr_status, .wr_req, .wr_value, .disp);

// ### sim/fpm_operator.sv
// operator model pressing the front panel keys
`timescale 1ns/1ps
module fpm_operator (
  // clock
  input wire logic core_clk,
  // raw key pins, high while held
  output logic [4:0] key_pin
);
  // an open switch reads low, so released keys sit at 0
  initial key_pin = 5'h00;
  // short holds model contact bounce; the long gap lets release settle
  task automatic press(input int k, input int hold);
    @(negedge core_clk);
    key_pin[k] = 1'b1;
    repeat (hold) @(negedge core_clk);
    key_pin[k] = 1'b0;
    repeat (80) @(negedge core_clk);
  endtask
endmodule // fpm_operator

// ### sim/tb.sv
// self-checking testbench for the front panel mode controller
`timescale 1ns/1ps
`include "fpm_regs.svh"
module tb;
  // ==========================
  // signals
  logic core_clk, rst, alarm_new, alarm_active, wr_done, wr_req;
  logic [4:0] key_pin;
  logic signed [15:0] wr_value;
  // lower limit is driven so that a refused sign change can be shown
  logic signed [15:0] par_min = 16'shFC18;
  fpm_pkg::fpm_status_type wr_status;
  fpm_pkg::fpm_disp_type disp;
  int n_errors = 0;
  int n_checks = 0;
  int n_req = 0;
  // one tick every two cycles keeps the 20 s idle wait affordable
  fpm_panel #(.TICK_CYCLES(2)) fpm_panel_i (.core_clk(core_clk),
    .rst(rst), .key_pin(key_pin), .alarm_new(alarm_new),
    .alarm_active(alarm_active), .par_value(16'sh0064),
    .par_min(par_min), .par_max(16'sh03E8), .wr_done(wr_done),
    .wr_status(wr_status), .wr_req(wr_req), .wr_value(wr_value),
    .disp(disp));
  fpm_operator fpm_operator_i (.core_clk(core_clk), .key_pin(key_pin));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (wr_req === 1'b1) n_req++;
  // ==========================
  // helpers
  task automatic check(input logic [15:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_mode(input fpm_pkg::fpm_state_type m, input int n);
    for (int i = 0; i < n && disp.mode !== m; i++) @(negedge core_clk);
    if (disp.mode !== m) begin
      n_errors++;
      $display("mismatch at %0t: wait for mode timed out", $time);
      stop_test();
    end
  endtask
  task automatic key(input int k);
    fpm_operator_i.press(k, 60);
  endtask
  task automatic answer(input fpm_pkg::fpm_status_type s);
    @(negedge core_clk);
    wr_done = 1'b1;
    wr_status = s;
    @(negedge core_clk);
    wr_done = 1'b0;
  endtask
  // ==========================
  // scenarios
  task automatic t_boot();
    check(disp.mode, fpm_pkg::ST_BOOT, "boot mode");
    check(disp.show_id, 1'b1, "boot id");
    repeat (1900) @(negedge core_clk);
    check(disp.mode, fpm_pkg::ST_BOOT, "boot too short");
    wait_mode(fpm_pkg::ST_MON, 300);
    check(disp.show_id, 1'b0, "boot id off");
    $display("test boot done");
  endtask
  task automatic t_mon();
    key(`FPM_K_UP);
    check(disp.mon_sel, 5'h01, "monitor up");
    check(disp.show_id, 1'b1, "monitor id");
    fpm_operator_i.press(`FPM_K_UP, 300);
    check(disp.mon_sel, 5'h02, "long hold");
    fpm_operator_i.press(`FPM_K_UP, 6);
    check(disp.mon_sel, 5'h02, "bounce");
    repeat (3) key(`FPM_K_DOWN);
    check(disp.mon_sel, 5'h1A, "monitor wrap");
    key(`FPM_K_SET);
    check(disp.hex, 1'b1, "hex toggle");
    $display("test monitor done");
  endtask
  task automatic t_modes();
    key(`FPM_K_MODE);
    check(disp.mode, fpm_pkg::ST_PAR, "alarm skipped");
    key(`FPM_K_MODE);
    check(disp.mode, fpm_pkg::ST_MON, "par to mon");
    alarm_active = 1'b1;
    key(`FPM_K_MODE);
    check(disp.mode, fpm_pkg::ST_ALARM, "mon to alarm");
    key(`FPM_K_MODE);
    check(disp.mode, fpm_pkg::ST_PAR, "alarm to par");
    alarm_active = 1'b0;
    $display("test modes done");
  endtask
  task automatic t_par();
    key(`FPM_K_SHIFT);
    check(disp.group, 3'h1, "group step");
    key(`FPM_K_DOWN);
    check(disp.code, 7'h4F, "code wrap down");
    key(`FPM_K_UP);
    check(disp.code, 7'h00, "code wrap up");
    repeat (4) key(`FPM_K_SHIFT);
    check(disp.group, 3'h0, "group wrap");
    $display("test parameter done");
  endtask
  task automatic t_edit();
    int r;
    key(`FPM_K_SET);
    check(disp.mode, fpm_pkg::ST_EDIT, "edit entry");
    check(disp.value, 16'h0064, "edit value");
    key(`FPM_K_UP);
    check(disp.value, 16'h0065, "edit up");
    key(`FPM_K_SHIFT);
    check(disp.digit, 3'h1, "digit left");
    key(`FPM_K_DOWN);
    check(disp.value, 16'h005B, "tens down");
    r = n_req;
    key(`FPM_K_MODE);
    check(disp.mode, fpm_pkg::ST_PAR, "edit abandon");
    check(16'(n_req - r), 16'h0000, "abandon wrote");
    $display("test edit done");
  endtask
  task automatic t_save();
    fpm_pkg::fpm_status_type s;
    int r;
    for (int i = 0; i < 6; i++) begin
      s = fpm_pkg::fpm_status_type'(i);
      key(`FPM_K_SET);
      key(`FPM_K_UP);
      r = n_req;
      key(`FPM_K_SET);
      check(16'(n_req - r), 16'h0001, "one request");
      check(wr_value, 16'h0065, "saved value");
      check(disp.mode, fpm_pkg::ST_WAIT, "waiting store");
      answer(s);
      check(disp.mode, fpm_pkg::ST_STAT, "status shown");
      check(disp.status, s, "status code");
      if (s == fpm_pkg::WS_SAVED || s == fpm_pkg::WS_REPOWER) begin
        wait_mode(fpm_pkg::ST_PAR, 2200);
      end else begin
        wait_mode(fpm_pkg::ST_EDIT, 2200);
        key(`FPM_K_MODE);
      end
    end
    $display("test save done");
  endtask
  task automatic t_sign();
    key(`FPM_K_SET);
    fpm_operator_i.press(`FPM_K_SHIFT, 4300);
    check(disp.value, 16'hFF9C, "sign flip");
    check(disp.digit, 3'h1, "shift also moves");
    key(`FPM_K_MODE);
    par_min = 16'sh0000;
    key(`FPM_K_SET);
    fpm_operator_i.press(`FPM_K_SHIFT, 4300);
    check(disp.value, 16'h0064, "sign flip refused");
    key(`FPM_K_MODE);
    par_min = 16'shFC18;
    $display("test sign done");
  endtask
  task automatic t_alarm();
    @(negedge core_clk);
    alarm_new = 1'b1;
    @(negedge core_clk);
    alarm_new = 1'b0;
    check(disp.mode, fpm_pkg::ST_ALARM, "forced alarm");
    alarm_active = 1'b1;
    key(`FPM_K_MODE);
    check(disp.mode, fpm_pkg::ST_PAR, "alarm left");
    key(`FPM_K_UP);
    repeat (36000) @(negedge core_clk);
    check(disp.mode, fpm_pkg::ST_PAR, "idle too soon");
    wait_mode(fpm_pkg::ST_ALARM, 8000);
    $display("test alarm done");
  endtask
  initial begin
    rst = 1'b1;
    alarm_new = 1'b0;
    alarm_active = 1'b0;
    wr_done = 1'b0;
    wr_status = fpm_pkg::WS_SAVED;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_boot();
    t_mon();
    t_modes();
    t_par();
    t_edit();
    t_save();
    t_sign();
    t_alarm();
    stop_test();
  end
endmodule // tb
